// ### hdl/epwm_regs.vh
/*
  Register map and reset values for the eight channel PWM timer.
  Assumes a 32-bit APB slave with one aligned word per register.
*/
`ifndef EPWM_REGS_VH
`define EPWM_REGS_VH

`define EPWM_NCH          8
`define EPWM_CW           8
// offsets (byte addresses)
`define EPWM_OFS_ENABLE   12'h000
`define EPWM_OFS_POLARITY 12'h004
`define EPWM_OFS_ALIGN    12'h008
`define EPWM_OFS_CONCAT   12'h00C
`define EPWM_OFS_STATUS   12'h010
`define EPWM_OFS_PERIOD0  12'h040
`define EPWM_OFS_DUTY0    12'h060
`define EPWM_OFS_COUNT0   12'h080
// reset values
`define EPWM_RST_ENABLE   8'h00
`define EPWM_RST_POLARITY 8'hFF
`define EPWM_RST_ALIGN    8'h00
`define EPWM_RST_CONCAT   4'h0
`define EPWM_RST_PERIOD   8'hFF
`define EPWM_RST_DUTY     8'h00

`endif

// ### hdl/epwm_counter.v
/*
  One W-bit (16 by default) PWM counter and comparator, usable as an 8-bit channel or
  as the joined counter of a channel pair.
  Assumes period, duty and mode are steady or change only between periods.
*/
`default_nettype none

module epwm_counter #(
  parameter W = 16
) (
  // clock and reset
  input wire sys_clk_i,
  input wire rst_i,
  // control
  input wire enable_i,
  input wire center_i,
  input wire polarity_i,
  input wire [W-1:0] period_i,
  input wire [W-1:0] duty_i,
  // state
  output reg [W-1:0] count_o,
  output reg wave_o
);

  reg down_reg;
  reg [W-1:0] cnt_next;
  reg down_next;
  reg active;

  always @* begin
    cnt_next = count_o;
    down_next = down_reg;
    if (!enable_i) begin
      cnt_next = {W{1'b0}};
      down_next = 1'b0;
    end else if (!center_i) begin
      // left aligned: count up, restart after period - 1
      if (count_o >= period_i - {{(W-1){1'b0}}, 1'b1} || period_i == {W{1'b0}})
        cnt_next = {W{1'b0}};
      else
        cnt_next = count_o + {{(W-1){1'b0}}, 1'b1};
      down_next = 1'b0;
    end else if (!down_reg) begin
      // centre aligned: up to period, then down to zero
      if (count_o >= period_i) begin
        down_next = 1'b1;
        cnt_next = (period_i == {W{1'b0}}) ? {W{1'b0}} :
                   count_o - {{(W-1){1'b0}}, 1'b1};
      end else begin
        cnt_next = count_o + {{(W-1){1'b0}}, 1'b1};
      end
    end else begin
      if (count_o == {W{1'b0}}) begin
        down_next = 1'b0;
        cnt_next = (period_i == {W{1'b0}}) ? {W{1'b0}} : {{(W-1){1'b0}}, 1'b1};
      end else begin
        cnt_next = count_o - {{(W-1){1'b0}}, 1'b1};
      end
    end
  end

  always @* begin
    // duty 0 never active; always active for duty >= period left aligned, duty > period centre aligned
    active = enable_i && (count_o < duty_i);
  end

  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      count_o <= {W{1'b0}};
      down_reg <= 1'b0;
      wave_o <= 1'b0;
    end else begin
      count_o <= cnt_next;
      down_reg <= down_next;
      wave_o <= active ? polarity_i : ~polarity_i;
    end
  end

endmodule // epwm_counter

`default_nettype wire

// ### hdl/epwm_top.v
/*
  Eight channel 8-bit PWM timer with pair joining, APB register slave.
  Assumes one 40 MHz clock, synchronous active high reset, APB master.
*/
// The placing of the registers and register access over APB are this design's own decisions.
`default_nettype none
`include "epwm_regs.vh"

module epwm_top #(
  parameter NCH = `EPWM_NCH
) (
  // clock and reset
  input wire sys_clk_i,
  input wire rst_i,
  // apb slave
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [11:0] paddr_i,
  input wire [31:0] pwdata_i,
  input wire [3:0] pstrb_i,
  output reg [31:0] prdata_o,
  output reg pready_o,
  output reg pslverr_o,
  // pwm pins
  output reg [NCH-1:0] pwm_o
);

  localparam NP = NCH / 2;

  reg [NCH-1:0] enable_reg;
  reg [NCH-1:0] polarity_reg;
  reg [NCH-1:0] align_reg;
  reg [NP-1:0] concat_reg;
  reg [7:0] period_reg [0:NCH-1];
  reg [7:0] duty_reg [0:NCH-1];

  wire [NCH-1:0] wave;
  wire [NCH-1:0] pin_next;
  wire [15:0] cnt [0:NCH-1];

  // decode a per-channel array offset; returns 1 on hit, the index comes from idx
  function hit_array;
    input [11:0] addr;
    input [11:0] base;
    begin
      hit_array = (addr[11:5] == base[11:5]) && (addr[1:0] == 2'b00);
    end
  endfunction

  wire acc = psel_i && penable_i && !pready_o;
  // write lands on the completing edge, when pready is seen high
  wire wr = psel_i && penable_i && pready_o && pwrite_i && pstrb_i[0];
  wire [2:0] idx = paddr_i[4:2];

  // per-pair counters: low counter always 8-bit, high one 8 or 16 bit
  genvar p;
  generate
    for (p = 0; p < NP; p = p + 1) begin : g_pair
      wire join_w = concat_reg[p];
      wire [15:0] per_hi = join_w ? {period_reg[2*p+1], period_reg[2*p]} :
                                    {8'h00, period_reg[2*p+1]};
      wire [15:0] dty_hi = join_w ? {duty_reg[2*p+1], duty_reg[2*p]} :
                                    {8'h00, duty_reg[2*p+1]};
      wire [7:0] cnt_lo;
      wire [15:0] cnt_hi;
      epwm_counter #(.W(8)) u_lo (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .enable_i(enable_reg[2*p] && !join_w),
        .center_i(align_reg[2*p]),
        .polarity_i(polarity_reg[2*p]),
        .period_i(period_reg[2*p]),
        .duty_i(duty_reg[2*p]),
        .count_o(cnt_lo),
        .wave_o(wave[2*p])
      );
      // joined pair uses high channel's enable, polarity, alignment
      epwm_counter #(.W(16)) u_hi (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .enable_i(enable_reg[2*p+1]),
        .center_i(align_reg[2*p+1]),
        .polarity_i(polarity_reg[2*p+1]),
        .period_i(per_hi),
        .duty_i(dty_hi),
        .count_o(cnt_hi),
        .wave_o(wave[2*p+1])
      );
      assign cnt[2*p] = join_w ? {8'h00, cnt_hi[7:0]} : {8'h00, cnt_lo};
      assign cnt[2*p+1] = join_w ? {8'h00, cnt_hi[15:8]} : cnt_hi;

      // low output parked at its inactive level when joined
      assign pin_next[2*p] = join_w ? ~polarity_reg[2*p] : wave[2*p];
      assign pin_next[2*p+1] = wave[2*p+1];
    end
  endgenerate

  // one driver for the whole pin vector
  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      pwm_o <= {NCH{1'b0}};
    end else begin
      pwm_o <= pin_next;
    end
  end

  // register writes
  integer i;
  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      enable_reg <= `EPWM_RST_ENABLE;
      polarity_reg <= `EPWM_RST_POLARITY;
      align_reg <= `EPWM_RST_ALIGN;
      concat_reg <= `EPWM_RST_CONCAT;
      for (i = 0; i < NCH; i = i + 1) begin
        period_reg[i] <= `EPWM_RST_PERIOD;
        duty_reg[i] <= `EPWM_RST_DUTY;
      end
    end else if (wr) begin
      case (paddr_i)
        `EPWM_OFS_ENABLE: enable_reg <= pwdata_i[7:0];
        `EPWM_OFS_POLARITY: polarity_reg <= pwdata_i[7:0];
        `EPWM_OFS_ALIGN: align_reg <= pwdata_i[7:0];
        `EPWM_OFS_CONCAT: concat_reg <= pwdata_i[3:0];
        default: begin
          if (hit_array(paddr_i, `EPWM_OFS_PERIOD0))
            period_reg[idx] <= pwdata_i[7:0];
          else if (hit_array(paddr_i, `EPWM_OFS_DUTY0))
            duty_reg[idx] <= pwdata_i[7:0];
        end
      endcase
    end
  end

  // read mux and response
  reg [31:0] rd_next;
  reg err_next;
  always @* begin
    rd_next = 32'h0000_0000;
    err_next = 1'b0;
    case (paddr_i)
      `EPWM_OFS_ENABLE: rd_next = {24'h000000, enable_reg};
      `EPWM_OFS_POLARITY: rd_next = {24'h000000, polarity_reg};
      `EPWM_OFS_ALIGN: rd_next = {24'h000000, align_reg};
      `EPWM_OFS_CONCAT: rd_next = {28'h0000000, concat_reg};
      `EPWM_OFS_STATUS: rd_next = {24'h000000, pwm_o};
      default: begin
        if (hit_array(paddr_i, `EPWM_OFS_PERIOD0))
          rd_next = {24'h000000, period_reg[idx]};
        else if (hit_array(paddr_i, `EPWM_OFS_DUTY0))
          rd_next = {24'h000000, duty_reg[idx]};
        else if (hit_array(paddr_i, `EPWM_OFS_COUNT0))
          rd_next = {24'h000000, cnt[idx][7:0]};
        else
          err_next = 1'b1;
      end
    endcase
  end

  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      prdata_o <= 32'h0000_0000;
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
    end else begin
      pready_o <= acc;
      pslverr_o <= acc && err_next;
      prdata_o <= (acc && !pwrite_i) ? rd_next : 32'h0000_0000;
    end
  end

endmodule // epwm_top

`default_nettype wire

// ### verification/epwm_monitor.sv
/* port checker for epwm_top
   assumes apb master holds request until pready */
`default_nettype none
module epwm_monitor #(parameter NCH = 8) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // apb
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  // pins
  input wire logic [NCH-1:0] pwm_o
);
  logic cc_reg;
  logic pol_reg;
  wire wr = pready_o && pwrite_i && pstrb_i[0];
  always @(posedge sys_clk_i) begin
    cc_reg <= rst_i ? 1'b0 : (wr && paddr_i == 12'h00C) ? pwdata_i[0] : cc_reg;
    pol_reg <= rst_i ? 1'b1 : (wr && paddr_i == 12'h004) ? pwdata_i[0] : pol_reg;
  end
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  a_ready_after_access: assert property ($rose(penable_i) && psel_i |=> pready_o)
    else $error("late ready");
  a_ready_one_pulse: assert property (pready_o |=> !pready_o)
    else $error("ready too long");
  a_err_with_ready: assert property (pslverr_o |-> pready_o)
    else $error("stray error");
  a_data_idle_zero: assert property (!pready_o |-> prdata_o == 32'h0)
    else $error("stray read data");
  a_read_width: assert property (pready_o |-> prdata_o[31:8] == 24'h0)
    else $error("wide read data");
  a_unmapped_err: assert property (pready_o && paddr_i >= 12'h0A0 |-> pslverr_o)
    else $error("no error");
  a_mapped_ok: assert property (pready_o && paddr_i <= 12'h010 |-> !pslverr_o)
    else $error("false error");
  a_low_idle: assert property (cc_reg && $past(cc_reg, 3) && $past(pol_reg, 3) == pol_reg
    |-> pwm_o[0] == !pol_reg)
    else $error("low pin active");
  cover property (pslverr_o);
  cover property (cc_reg && pwm_o[1]);
  cover property (pready_o && !pwrite_i);
endmodule // epwm_monitor
bind epwm_top epwm_monitor #(.NCH(NCH)) i_mon (.*);
`default_nettype wire

// ### verification/epwm_top_bench.sv
/* self-checking bench for epwm_top
   drives apb at rising edges, counts pin activity */
`default_nettype none
module epwm_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk_i = 0, rst_i = 1, psel = 0, pen = 0, pwr = 0, err;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, rd, seed = 32'h71C831AC;
  logic [11:0] ra[6] = '{12'h000, 12'h004, 12'h008, 12'h00C, 12'h040, 12'h060};
  logic [31:0] rv[6] = '{32'h0, 32'hFF, 32'h0, 32'h0, 32'hFF, 32'h0};
  wire [31:0] prdata;
  wire pready, perr;
  wire [7:0] pwm;
  int fail_count = 0, checks = 0, cyc = 0, p, d, i, n;
  bit c, pol;
  epwm_top i_dut (.sys_clk_i, .rst_i, .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
    .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(4'hF), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(perr), .pwm_o(pwm));
  initial forever #12.5 sys_clk_i = ~sys_clk_i;
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic int ones(int p, int d, bit c, bit pol);
    int a;
    a = c ? (d == 0 ? 0 : d > p ? 2 * p : 2 * d - 1) : (d > p ? p : d);
    return pol ? a : (c ? 2 * p : p) - a;
  endfunction
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic apb(bit w, logic [11:0] a, logic [31:0] v);
    @(posedge sys_clk_i);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= v;
    @(posedge sys_clk_i);
    pen <= 1'b1;
    // pready sampled at the rising edge, request held until then
    do @(posedge sys_clk_i); while (pready !== 1'b1);
    rd = prdata;
    err = perr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic meas(int ch, int win);
    n = 0;
    repeat (win) begin
      @(negedge sys_clk_i);
      n += (pwm[ch] === 1'b1);
    end
  endtask
  task automatic tally_and_finish();
    if (fail_count == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 60000) begin
      fail_count++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (8) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    chk("idle pins", 32'h0, pwm);
    foreach (ra[k]) begin
      apb(0, ra[k], 0);
      chk("reset value", rv[k], rd);
    end
    apb(0, 12'h0FC, 0);
    chk("unmapped error", 1, err);
    chk("unmapped data", 0, rd);
    for (i = 0; i < 8; i++) begin
      p = 2 + rnd() % 30;
      d = i == 0 ? 0 : i == 1 ? p : rnd() % (p + 3);
      c = rnd();
      pol = rnd();
      apb(1, 12'h000, 0);
      apb(1, 12'(12'h040 + 4 * i), p);
      apb(1, 12'(12'h060 + 4 * i), d);
      apb(1, 12'h008, c << i);
      apb(1, 12'h004, ~(32'h1 << i) | pol << i);
      apb(1, 12'h000, 1 << i);
      repeat (4 * p + 4) @(posedge sys_clk_i);
      meas(i, c ? 2 * p : p);
      chk("active cycles", ones(p, d, c, pol), n);
    end
    apb(1, 12'h000, 0);
    apb(1, 12'h004, 32'hFF);
    apb(1, 12'h008, 0);
    apb(1, 12'h00C, 1);
    p = 256 + rnd() % 64;
    d = rnd() % 330;
    apb(1, 12'h040, p & 255);
    apb(1, 12'h044, p >> 8);
    apb(1, 12'h060, d & 255);
    apb(1, 12'h064, d >> 8);
    apb(1, 12'h000, 2);
    repeat (2 * p + 4) @(posedge sys_clk_i);
    meas(1, p);
    chk("joined active", ones(p, d, 0, 1), n);
    meas(0, p);
    chk("joined low pin", 0, n);
    tally_and_finish();
  end
endmodule // epwm_top_bench
`default_nettype wire
